// ### bench/gpio_port_checker.sv
// Port-level checks for the eight-pin port.
// Assumes it is bound to gpio_port and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module gpio_port_checker
  import port_pkg::*;
(
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pins.
  input wire logic [7:0]  pin_oe_n,
  input wire logic [7:0]  analog_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_in3; pin_oe_n[INPUT_ONLY_BIT]; endproperty
  a_in3: assert property (p_in3) else $error("pin three driven");
  property p_rst; $rose(aresetn) |-> analog_enable == 8'hff && pin_oe_n == 8'hff; endproperty
  a_rst: assert property (p_rst) else $error("bad pin state after reset");
  property p_dir; $changed(pin_oe_n) |-> $past(s_axi_bvalid); endproperty
  a_dir: assert property (p_dir) else $error("drivers moved without a write");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read data late");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write response late");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response not held");
  property p_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
endmodule
bind gpio_port gpio_port_checker chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_oe_n, .analog_enable);
`default_nettype wire

// ### bench/pin_model.sv
// Package pins: the port driver wins, then an outside source.
// Assumes no pull resistor, so an undriven pin wanders every cycle.
`timescale 1ns/10ps
`default_nettype none
module pin_model (
  // Port side.
  input  wire logic       aclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  // Outside source.
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_in
);
  logic wander = 1'h0;
  always @(posedge aclk) wander <= ~wander;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : wander;
    end
  end
endmodule
`default_nettype wire

// ### bench/test_gpio_port.sv
// Random and corner tests of the port over the register bus.
// Assumes pin_model on the pins and offsets from port_pkg.
`timescale 1ns/10ps
`default_nettype none
module test_gpio_port
  import port_pkg::*;
;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  periph_en [PERIPH_COUNT] = '{default: '0};
  logic [7:0]  periph_out [PERIPH_COUNT] = '{default: '0};
  logic [7:0]  pin_in, pin_out, pin_oe_n, analog_enable, ext_val = '0, ext_en = '0;
  logic [15:0] seed = 16'ha978;
  int          miscompares = 0, n_compared = 0, cycles = 0;
  always #2.5 aclk = ~aclk;
  gpio_port dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .periph_en, .periph_out, .pin_in, .pin_out, .pin_oe_n, .analog_enable);
  pin_model pins (.aclk, .pin_out, .pin_oe_n, .ext_val, .ext_en, .pin_in);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  // Peripheral 0 beats peripheral 1, which beats the latch, bit by bit.
  function automatic logic [7:0] pout(input logic [7:0] l);
    return (periph_en[0] & periph_out[0]) | (~periph_en[0] & periph_en[1] & periph_out[1])
      | (~periph_en[0] & ~periph_en[1] & l);
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  // Ready stands from the request until the answer is sampled, then drops.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk($sformatf("rdata %h", a), s_axi_rdata, {24'h0, e});
    chk("rresp", s_axi_rresp, er);
  endtask
  task automatic end_sim();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d, a, l, m, p, v;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    ext_en <= 8'hff;
    ext_val <= 8'hff;
    @(posedge aclk);
    chk("oe_n", pin_oe_n, DIRECTION_RESET);
    rc(OFF_DIRECTION, DIRECTION_RESET, RESP_OKAY);
    rc(OFF_ANALOG_SEL, ANALOG_RESET, RESP_OKAY);
    rc(OFF_OUT_LATCH, LATCH_RESET, RESP_OKAY);
    rc(OFF_PIN_LEVEL, 8'h00, RESP_OKAY);
    wr(4'h6, 32'hff, 4'hf, RESP_SLVERR);
    rc(4'h6, 8'h00, RESP_SLVERR);
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 8'h00 : rnd();
      a = (i == 0) ? 8'hff : rnd();
      l = rnd();
      periph_en[0] <= rnd() & rnd();
      periph_out[0] <= rnd();
      periph_en[1] <= rnd() & rnd();
      periph_out[1] <= rnd();
      ext_val <= rnd();
      ext_en <= d | INPUT_ONLY_MASK;
      wr(OFF_DIRECTION, {24'h0, d}, 4'hf, RESP_OKAY);
      wr(OFF_ANALOG_SEL, {24'h0, a}, 4'hf, RESP_OKAY);
      wr(OFF_OUT_LATCH, {24'h0, l}, 4'hf, RESP_OKAY);
      repeat (6) @(posedge aclk);
      m = d | INPUT_ONLY_MASK;
      p = (~m & pout(l)) | (m & ext_val);
      chk("oe_n", pin_oe_n, m);
      chk("pin_out", pin_out & ~m, pout(l) & ~m);
      chk("analog", analog_enable, a);
      rc(OFF_DIRECTION, m, RESP_OKAY);
      rc(OFF_OUT_LATCH, l, RESP_OKAY);
      rc(OFF_PIN_LEVEL, p & ~a, RESP_OKAY);
      v = rnd();
      wr(OFF_PIN_LEVEL, {rnd(), rnd(), rnd(), v}, {3'h0, ~i[0]}, RESP_OKAY);
      rc(OFF_OUT_LATCH, i[0] ? p & ~a : v, RESP_OKAY);
    end
    end_sim();
  end
endmodule
`default_nettype wire

// ### hdl/gpio_port.sv
// Eight-pin bidirectional port with direction, output latch and analog select,
// reached over AXI4-Lite. Assumes pins resolve their wire level from pin_oe_n.
// Behaviour
// - Eight pins, seven of them bidirectional, each with direction, latch and analog-select bits.
// - Direction bit one turns the pin driver off; pin is an input.
// - Direction bit zero drives the pin with its latch bit.
// - Pin three is input only; its direction bit always reads one.
// - Reading pin-level register returns live pin states, not the latch.
// - Writing pin-level register is read-modify-write into the output latch.
// - Direction bits still control drivers on analog pins; keep them set there.
// - Analog-selected pins read as zero digitally; analog functions enabled.
// - Analog select does not stop digital output driving the latch value.
// - All analog-select bits reset to analog mode; software clears them.
// - Enabled peripheral outputs override the port latch, highest priority wins.
`timescale 1ns/10ps
`default_nettype none
module gpio_port
  import port_pkg::*;
(
  // Clock and reset.
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address.
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // AXI4-Lite write response.
  output logic      [1:0]           s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  // AXI4-Lite read data.
  output logic      [31:0]          s_axi_rdata,
  output logic      [1:0]           s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Peripheral outputs; index 0 has the highest priority.
  input  wire logic [PIN_COUNT-1:0] periph_en [PERIPH_COUNT],
  input  wire logic [PIN_COUNT-1:0] periph_out [PERIPH_COUNT],
  // Port pins.
  input  wire logic [PIN_COUNT-1:0] pin_in,
  output logic      [PIN_COUNT-1:0] pin_out,
  output logic      [PIN_COUNT-1:0] pin_oe_n,
  // Analog enable per pin for the converters.
  output logic      [PIN_COUNT-1:0] analog_enable
);

  ////////////////////////////////////////////////////////////////////////////////

  logic [PIN_COUNT-1:0] direction_control_reg;
  logic [PIN_COUNT-1:0] output_latch_reg;
  logic [PIN_COUNT-1:0] analog_select_reg;
  logic [PIN_COUNT-1:0] pin_stable;
  logic [PIN_COUNT-1:0] pin_level_reg;
  logic [PIN_COUNT-1:0] direction_view;
  logic [PIN_COUNT-1:0] next_pin_out;
  logic [ADDR_W-1:0]    aw_addr;
  logic                 aw_held;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 w_held;
  logic                 do_write;
  logic [31:0]          next_rdata;
  logic [1:0]           next_rresp;

  pin_sync u_sync (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pin_raw    (pin_in),
    .pin_stable (pin_stable)
  );

  // Analog-selected pins read as zero on every digital path.
  assign pin_level_reg  = pin_stable & ~analog_select_reg;
  assign direction_view = direction_control_reg | INPUT_ONLY_MASK;

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order and held.

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      unique case (aw_addr)
        OFF_PIN_LEVEL, OFF_DIRECTION, OFF_OUT_LATCH, OFF_ANALOG_SEL: s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register state. Only byte lane 0 carries data.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      direction_control_reg <= DIRECTION_RESET;
    end else if (do_write && aw_addr == OFF_DIRECTION && w_strb[0]) begin
      direction_control_reg <= w_data[PIN_COUNT-1:0] | INPUT_ONLY_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_select_reg <= ANALOG_RESET;
    end else if (do_write && aw_addr == OFF_ANALOG_SEL && w_strb[0]) begin
      analog_select_reg <= w_data[PIN_COUNT-1:0];
    end
  end

  // A write to the pin-level register lands in the latch. Byte writes are the
  // whole register, so the modify step is the new byte replacing the sampled pins;
  // a strobe without byte lane 0 keeps the sampled pin levels, which is the hazard software sees.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_latch_reg <= LATCH_RESET;
    end else if (do_write && aw_addr == OFF_PIN_LEVEL) begin
      output_latch_reg <= w_strb[0] ? w_data[PIN_COUNT-1:0] : pin_level_reg;
    end else if (do_write && aw_addr == OFF_OUT_LATCH && w_strb[0]) begin
      output_latch_reg <= w_data[PIN_COUNT-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle from address acceptance to data.

  always_comb begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    unique case (s_axi_araddr)
      OFF_PIN_LEVEL:  next_rdata[PIN_COUNT-1:0] = pin_level_reg;
      OFF_DIRECTION:  next_rdata[PIN_COUNT-1:0] = direction_view;
      OFF_OUT_LATCH:  next_rdata[PIN_COUNT-1:0] = output_latch_reg;
      OFF_ANALOG_SEL: next_rdata[PIN_COUNT-1:0] = analog_select_reg;
      default:        next_rresp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rresp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive. Peripherals take the pin ahead of the latch; the driver follows
  // the direction bit alone, whatever the analog setting.

  always_comb begin
    next_pin_out = output_latch_reg;
    for (int p = PERIPH_COUNT - 1; p >= 0; p--) begin
      next_pin_out = (periph_en[p] & periph_out[p]) | (~periph_en[p] & next_pin_out);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out       <= LATCH_RESET;
      pin_oe_n      <= DIRECTION_RESET;
      analog_enable <= ANALOG_RESET;
    end else begin
      pin_out       <= next_pin_out;
      pin_oe_n      <= direction_view;
      analog_enable <= analog_select_reg;
    end
  end
endmodule
`default_nettype wire

// ### hdl/pin_sync.sv
// Three-stage synchroniser for the eight pin inputs with agreement filter.
// Assumes pins are asynchronous to aclk; the first stage feeds only the second.
`timescale 1ns/10ps
`default_nettype none
module pin_sync
  import port_pkg::*;
(
  // Clock and reset.
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Raw and filtered pin levels.
  input  wire logic [PIN_COUNT-1:0] pin_raw,
  output logic      [PIN_COUNT-1:0] pin_stable
);
  logic [PIN_COUNT-1:0] stage1;
  logic [PIN_COUNT-1:0] stage2;
  logic [PIN_COUNT-1:0] stage3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin_raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A level counts only once the second and third stages agree.
  genvar i;
  for (i = 0; i < PIN_COUNT; i++) begin : g_agree
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_stable[i] <= 1'b0;
      end else if (stage2[i] == stage3[i]) begin
        pin_stable[i] <= stage3[i];
      end
    end
  end
endmodule
`default_nettype wire

// ### hdl/port_pkg.sv
// Constants for the eight-pin bidirectional port: register map, reset values,
// pin positions and synchroniser depth. Assumes an AXI4-Lite slave with 32-bit data.
package port_pkg;
  localparam int          PIN_COUNT        = 8;
  localparam int          ADDR_W           = 4;
  localparam int          SYNC_STAGES      = 3;
  localparam int          PERIPH_COUNT     = 2;
  // Register byte offsets.
  localparam logic [3:0]  OFF_PIN_LEVEL    = 4'h0;
  localparam logic [3:0]  OFF_DIRECTION    = 4'h4;
  localparam logic [3:0]  OFF_OUT_LATCH    = 4'h8;
  localparam logic [3:0]  OFF_ANALOG_SEL   = 4'hc;
  // Field positions and reset values.
  localparam int          INPUT_ONLY_BIT   = 3;
  localparam logic [7:0]  DIRECTION_RESET  = 8'hff;
  localparam logic [7:0]  ANALOG_RESET     = 8'hff;
  localparam logic [7:0]  LATCH_RESET      = 8'h00;
  localparam logic [7:0]  INPUT_ONLY_MASK  = 8'h08;
  // AXI responses.
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage
